/* core/hprw_regs.vh */
// Constants for the host power, reset and watchdog supervisor
// Functional notes
// - Control lines float idle, driven only during pulses
// - Host up, confirm held 4s: reset 1s pulse
// - Reset message shown; commands refused until reboot done
// - Host down, confirm 0.25s: power pulse, reboot
// - Cancel held 4s pulses power, up to 5s more
// - Blank display and backlight while host sense low
// - Mask bits 0..2 select automatic or forced polarity
// - Mask bits 4..7 enable blank, reset, power-on, power-off
// - Pulse length in 1/32s; 255 holds until host sense changes
// - Sense select 0 picks pin, 1 picks 5V
// - Stay awake on standby; reboot when sense rises
// - Switch command 0x1C, 1-3 bytes, answer 0x5C
// - Watchdog timeout zero disables the watchdog
// - Expiry resets host, watchdog then stays disabled
// - Watchdog command 0x1D, one byte, answer 0x5D
// - Poll reports down, pressed and released keys
// - One-hot keys: confirm bit 1, cancel bit 2
`ifndef HPRW_REGS_VH
`define HPRW_REGS_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define HPRW_CLK_PERIOD_NS   20
`define HPRW_TICK_PERIOD_NS  31250000
`define HPRW_RST_HOLD_TICKS  8'd128
`define HPRW_PON_HOLD_TICKS  8'd8
`define HPRW_POFF_HOLD_TICKS 8'd128
`define HPRW_RST_PULSE_TICKS 9'd32
`define HPRW_EXT_TICKS       9'd160
`define HPRW_BOOT_TICKS      9'd16
`define HPRW_SUB_LAST        5'd31
`define HPRW_LEN_HOLD        8'hff

// ----------------------------------------
// Function mask fields
// ----------------------------------------
`define HPRW_BIT_AUTO        0
`define HPRW_BIT_RST_INV     1
`define HPRW_BIT_PWR_INV     2
`define HPRW_BIT_BLANK       4
`define HPRW_BIT_KEY_RST     5
`define HPRW_BIT_KEY_PON     6
`define HPRW_BIT_KEY_POFF    7

// ----------------------------------------
// Keys, commands, reset values
// ----------------------------------------
`define HPRW_KEY_CONFIRM     1
`define HPRW_KEY_CANCEL      2
`define HPRW_CMD_ATX         8'h1c
`define HPRW_RSP_ATX         8'h5c
`define HPRW_CMD_WDOG        8'h1d
`define HPRW_RSP_WDOG        8'h5d
`define HPRW_MASK_RST        8'h00
`define HPRW_LEN_RST         8'd32
`define HPRW_SENSE_RST       1'b1
`define HPRW_MSG_NONE        2'd0
`define HPRW_MSG_RESET       2'd1
`define HPRW_MSG_PON         2'd2
`define HPRW_MSG_POFF        2'd3

`endif

/* core/hprw_sync.v */
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module hprw_sync #(
	parameter WIDTH = 1
) (
	// Clock and reset
	input  wire             clk_in,
	input  wire             rst_n_in,
	input  wire             ce_in,
	// Data
	input  wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_q;
	reg [WIDTH-1:0] sync_q;

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_q <= {WIDTH{1'b0}};
			sync_q <= {WIDTH{1'b0}};
		end else if (ce_in) begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;
endmodule
`default_nettype wire

/* core/hprw_tick.v */
// Divider producing the 1/32 second tick
`timescale 1ns/1ps
`default_nettype none
module hprw_tick #(
	parameter CYCLES = 1562500,
	parameter WIDTH  = 21
) (
	// Clock and reset
	input  wire clk_in,
	input  wire rst_n_in,
	input  wire ce_in,
	// Tick
	output wire tick_out
);
	localparam [31:0]      LAST_FULL = CYCLES - 1;
	localparam [WIDTH-1:0] LAST      = LAST_FULL[WIDTH-1:0];
	reg [WIDTH-1:0] cnt_q;

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_q <= {WIDTH{1'b0}};
		end else if (ce_in) begin
			if (cnt_q == LAST) begin
				cnt_q <= {WIDTH{1'b0}};
			end else begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end

	assign tick_out = ce_in & (cnt_q == LAST);
endmodule
`default_nettype wire

/* core/hprw_top.v */
// Host power, reset and watchdog supervisor
`timescale 1ns/1ps
`default_nettype none
`include "hprw_regs.vh"
module hprw_top #(
	parameter TICK_CYCLES = `HPRW_TICK_PERIOD_NS / `HPRW_CLK_PERIOD_NS
) (
	// Clock and reset
	input  wire       clk_in,
	input  wire       rst_n_in,
	input  wire       ce_in,
	// Decoded command port
	input  wire       cmd_valid_in,
	input  wire [7:0] cmd_type_in,
	input  wire [1:0] cmd_len_in,
	input  wire [7:0] cmd_data0_in,
	input  wire [7:0] cmd_data1_in,
	input  wire [7:0] cmd_data2_in,
	output wire       cmd_ready_out,
	output wire       rsp_valid_out,
	output wire [7:0] rsp_type_out,
	// Keypad
	input  wire [5:0] key_pins_in,
	input  wire       poll_in,
	output wire       poll_valid_out,
	output wire [5:0] keys_down_out,
	output wire [5:0] keys_pressed_out,
	output wire [5:0] keys_released_out,
	// Host sense
	input  wire       sense_5v_in,
	input  wire       sense_gpio_in,
	output wire       host_sense_out,
	// Host control lines
	input  wire       reset_pin_in,
	output wire       reset_pin_out,
	output wire       reset_pin_oe_out,
	input  wire       power_pin_in,
	output wire       power_pin_out,
	output wire       power_pin_oe_out,
	// Display side
	output wire       display_blank_out,
	output wire       backlight_off_out,
	output wire [1:0] message_out,
	output wire       self_reset_out,
	// Status
	output wire [7:0] func_mask_out,
	output wire [7:0] pulse_len_out,
	output wire       sense_sel_out,
	output wire [7:0] wdog_count_out,
	output wire       wdog_enabled_out
);
	localparam TICK_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

	localparam [2:0] ST_IDLE = 3'd0;
	localparam [2:0] ST_RST  = 3'd1;
	localparam [2:0] ST_PON  = 3'd2;
	localparam [2:0] ST_POFF = 3'd3;
	localparam [2:0] ST_LOCK = 3'd4;

	// ----------------------------------------
	// Hold counter step, shared by both keys
	// ----------------------------------------
	function [7:0] hold_next;
		input [7:0] cur;
		input       down;
		input       tick;
		begin
			if (!down) begin
				hold_next = 8'h00;
			end else if (tick && cur != 8'hff) begin
				hold_next = cur + 8'h01;
			end else begin
				hold_next = cur;
			end
		end
	endfunction

	wire       tick;
	wire [5:0] key_s;
	wire       s5v_s;
	wire       sgpio_s;
	wire       rst_line_s;
	wire       pwr_line_s;

	reg  [7:0] mask_q;
	reg  [7:0] len_q;
	reg        sense_sel_q;
	reg        rsp_valid_q;
	reg  [7:0] rsp_type_q;
	reg  [5:0] key_prev_q;
	reg  [5:0] press_acc_q;
	reg  [5:0] rel_acc_q;
	reg        poll_valid_q;
	reg  [5:0] down_q;
	reg  [5:0] pressed_q;
	reg  [5:0] released_q;
	reg  [7:0] conf_hold_q;
	reg  [7:0] canc_hold_q;
	reg        sense_prev_q;
	reg        wd_en_q;
	reg  [7:0] wd_sec_q;
	reg  [4:0] wd_sub_q;
	reg        wd_pend_q;
	reg  [2:0] state_q;
	reg  [2:0] state_d;
	reg  [8:0] cnt_q;
	reg  [8:0] cnt_d;
	reg        key_path_q;
	reg        key_path_d;
	reg  [1:0] msg_q;
	reg  [1:0] msg_d;
	reg        take_wd;
	reg        self_rst_q;
	reg        rst_oe_q;
	reg        pwr_oe_q;
	reg        oe_tick_q;
	reg        rst_idle_q;
	reg        pwr_idle_q;
	reg        rst_lvl_q;
	reg        pwr_lvl_q;
	reg        blank_q;

	// ----------------------------------------
	// Tick and input synchronisers
	// ----------------------------------------
	hprw_tick #(
		.CYCLES (TICK_CYCLES),
		.WIDTH  (TICK_W)
	) u_tick (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.ce_in    (ce_in),
		.tick_out (tick)
	);

	hprw_sync #(
		.WIDTH (6)
	) u_key_sync (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.ce_in    (ce_in),
		.async_in (key_pins_in),
		.sync_out (key_s)
	);

	hprw_sync #(
		.WIDTH (4)
	) u_pin_sync (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.ce_in    (ce_in),
		.async_in ({sense_5v_in, sense_gpio_in, reset_pin_in, power_pin_in}),
		.sync_out ({s5v_s, sgpio_s, rst_line_s, pwr_line_s})
	);

	wire host_sense = sense_sel_q ? s5v_s : sgpio_s;
	wire sense_rise = host_sense & ~sense_prev_q;

	// ----------------------------------------
	// Command decode and acknowledge
	// ----------------------------------------
	// Commands are refused through the keypad reset pulse and the boot display
	assign cmd_ready_out = (state_q != ST_LOCK) && !(state_q == ST_RST && key_path_q);
	wire cmd_fire = cmd_valid_in & cmd_ready_out;
	wire is_atx   = cmd_fire && (cmd_type_in == `HPRW_CMD_ATX) && (cmd_len_in != 2'd0);
	wire is_wd    = cmd_fire && (cmd_type_in == `HPRW_CMD_WDOG);

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mask_q      <= `HPRW_MASK_RST;
			len_q       <= `HPRW_LEN_RST;
			sense_sel_q <= `HPRW_SENSE_RST;
			rsp_valid_q <= 1'b0;
			rsp_type_q  <= 8'h00;
		end else if (ce_in) begin
			rsp_valid_q <= is_atx | is_wd;
			if (is_atx) begin
				mask_q     <= cmd_data0_in;
				rsp_type_q <= `HPRW_RSP_ATX;
				if (cmd_len_in >= 2'd2) begin
					len_q <= cmd_data1_in;
				end
				if (cmd_len_in == 2'd3) begin
					sense_sel_q <= (cmd_data2_in != 8'h00);
				end
			end else if (is_wd) begin
				rsp_type_q <= `HPRW_RSP_WDOG;
			end
		end
	end

	// ----------------------------------------
	// Keypad poll and hold timers
	// ----------------------------------------
	wire [5:0] key_rise = key_s & ~key_prev_q;
	wire [5:0] key_fall = ~key_s & key_prev_q;

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			key_prev_q   <= 6'h00;
			press_acc_q  <= 6'h00;
			rel_acc_q    <= 6'h00;
			poll_valid_q <= 1'b0;
			down_q       <= 6'h00;
			pressed_q    <= 6'h00;
			released_q   <= 6'h00;
			conf_hold_q  <= 8'h00;
			canc_hold_q  <= 8'h00;
			sense_prev_q <= 1'b0;
		end else if (ce_in) begin
			key_prev_q   <= key_s;
			sense_prev_q <= host_sense;
			poll_valid_q <= poll_in;
			// An edge in the poll cycle goes out now, so clearing loses nothing
			if (poll_in) begin
				down_q      <= key_s;
				pressed_q   <= press_acc_q | key_rise;
				released_q  <= rel_acc_q | key_fall;
				press_acc_q <= 6'h00;
				rel_acc_q   <= 6'h00;
			end else begin
				press_acc_q <= press_acc_q | key_rise;
				rel_acc_q   <= rel_acc_q | key_fall;
			end
			conf_hold_q <= hold_next(conf_hold_q, key_s[`HPRW_KEY_CONFIRM], tick);
			canc_hold_q <= hold_next(canc_hold_q, key_s[`HPRW_KEY_CANCEL], tick);
		end
	end

	// ----------------------------------------
	// Host watchdog
	// ----------------------------------------
	wire wd_expire = tick & wd_en_q & (wd_sub_q == `HPRW_SUB_LAST) & (wd_sec_q == 8'd1) & ~is_wd;

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wd_en_q   <= 1'b0;
			wd_sec_q  <= 8'h00;
			wd_sub_q  <= 5'd0;
			wd_pend_q <= 1'b0;
		end else if (ce_in) begin
			wd_pend_q <= wd_expire | (wd_pend_q & ~take_wd);
			if (is_wd) begin
				wd_en_q  <= (cmd_data0_in != 8'h00);
				wd_sec_q <= cmd_data0_in;
				wd_sub_q <= 5'd0;
			end else if (self_rst_q) begin
				wd_en_q <= 1'b0;
			end else if (tick && wd_en_q) begin
				if (wd_sub_q == `HPRW_SUB_LAST) begin
					wd_sub_q <= 5'd0;
					wd_sec_q <= wd_sec_q - 8'd1;
					if (wd_sec_q == 8'd1) begin
						wd_en_q <= 1'b0;
					end
				end else begin
					wd_sub_q <= wd_sub_q + 5'd1;
				end
			end
		end
	end

	// ----------------------------------------
	// Pulse sequencer
	// ----------------------------------------
	wire trig_rst  = mask_q[`HPRW_BIT_KEY_RST] & host_sense & (conf_hold_q == `HPRW_RST_HOLD_TICKS);
	wire trig_pon  = mask_q[`HPRW_BIT_KEY_PON] & ~host_sense & (conf_hold_q == `HPRW_PON_HOLD_TICKS);
	wire trig_poff = mask_q[`HPRW_BIT_KEY_POFF] & host_sense & (canc_hold_q == `HPRW_POFF_HOLD_TICKS);
	wire       len_hold = (len_q == `HPRW_LEN_HOLD);
	wire [8:0] len_ext  = {1'b0, len_q};
	wire [8:0] cnt_inc  = tick ? cnt_q + 9'd1 : cnt_q;

	always @* begin
		state_d    = state_q;
		cnt_d      = cnt_inc;
		key_path_d = key_path_q;
		msg_d      = msg_q;
		take_wd    = 1'b0;
		case (state_q)
			ST_IDLE: begin
				cnt_d = 9'd0;
				if (sense_rise) begin
					state_d = ST_LOCK;
				end else if (trig_rst) begin
					state_d    = ST_RST;
					key_path_d = 1'b1;
					msg_d      = `HPRW_MSG_RESET;
				end else if (trig_pon) begin
					state_d = ST_PON;
					msg_d   = `HPRW_MSG_PON;
				end else if (trig_poff) begin
					state_d = ST_POFF;
					msg_d   = `HPRW_MSG_POFF;
				end else if (wd_pend_q) begin
					state_d    = ST_RST;
					key_path_d = 1'b0;
					take_wd    = 1'b1;
				end
			end
			ST_RST: begin
				if (cnt_q >= `HPRW_RST_PULSE_TICKS) begin
					state_d = key_path_q ? ST_LOCK : ST_IDLE;
					cnt_d   = 9'd0;
					msg_d   = `HPRW_MSG_NONE;
				end
			end
			ST_PON: begin
				// Held length on power-on ends once the host comes up
				if (len_hold ? host_sense : (cnt_q >= len_ext)) begin
					state_d = ST_LOCK;
					cnt_d   = 9'd0;
					msg_d   = `HPRW_MSG_NONE;
				end
			end
			ST_POFF: begin
				if (len_hold ? ~host_sense :
					(cnt_q >= len_ext && (!key_s[`HPRW_KEY_CANCEL] || cnt_q >= len_ext + `HPRW_EXT_TICKS))) begin
					state_d = ST_IDLE;
					msg_d   = `HPRW_MSG_NONE;
				end
			end
			ST_LOCK: begin
				if (cnt_q >= `HPRW_BOOT_TICKS) begin
					state_d    = ST_IDLE;
					key_path_d = 1'b0;
				end
			end
			default: begin
				state_d = ST_IDLE;
				cnt_d   = 9'd0;
			end
		endcase
	end

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q    <= ST_IDLE;
			cnt_q      <= 9'd0;
			key_path_q <= 1'b0;
			msg_q      <= `HPRW_MSG_NONE;
			self_rst_q <= 1'b0;
			rst_oe_q   <= 1'b0;
			pwr_oe_q   <= 1'b0;
		end else if (ce_in) begin
			state_q    <= state_d;
			cnt_q      <= cnt_d;
			key_path_q <= key_path_d;
			msg_q      <= msg_d;
			self_rst_q <= (state_d == ST_LOCK) && (state_q != ST_LOCK);
			rst_oe_q   <= (state_d == ST_RST);
			pwr_oe_q   <= (state_d == ST_PON) || (state_d == ST_POFF);
		end
	end

	// ----------------------------------------
	// Line polarity and display blanking
	// ----------------------------------------
	// Idle level is learnt only after a whole tick released, so the synchroniser
	// lag never lets the driven level be mistaken for the idle one
	wire learn = tick & ~rst_oe_q & ~pwr_oe_q & ~oe_tick_q;

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			oe_tick_q  <= 1'b0;
			rst_idle_q <= 1'b1;
			pwr_idle_q <= 1'b1;
			rst_lvl_q  <= 1'b0;
			pwr_lvl_q  <= 1'b0;
			blank_q    <= 1'b0;
		end else if (ce_in) begin
			if (tick) begin
				oe_tick_q <= rst_oe_q | pwr_oe_q;
			end
			if (learn) begin
				rst_idle_q <= rst_line_s;
				pwr_idle_q <= pwr_line_s;
			end
			rst_lvl_q <= mask_q[`HPRW_BIT_AUTO] ? ~rst_idle_q : mask_q[`HPRW_BIT_RST_INV];
			pwr_lvl_q <= mask_q[`HPRW_BIT_AUTO] ? ~pwr_idle_q : mask_q[`HPRW_BIT_PWR_INV];
			blank_q   <= mask_q[`HPRW_BIT_BLANK] & ~host_sense;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign rsp_valid_out     = rsp_valid_q;
	assign rsp_type_out      = rsp_type_q;
	assign poll_valid_out    = poll_valid_q;
	assign keys_down_out     = down_q;
	assign keys_pressed_out  = pressed_q;
	assign keys_released_out = released_q;
	assign host_sense_out    = host_sense;
	assign reset_pin_out     = rst_lvl_q;
	assign reset_pin_oe_out  = rst_oe_q;
	assign power_pin_out     = pwr_lvl_q;
	assign power_pin_oe_out  = pwr_oe_q;
	assign display_blank_out = blank_q;
	assign backlight_off_out = blank_q;
	assign message_out       = msg_q;
	assign self_reset_out    = self_rst_q;
	assign func_mask_out     = mask_q;
	assign pulse_len_out     = len_q;
	assign sense_sel_out     = sense_sel_q;
	assign wdog_count_out    = wd_sec_q;
	assign wdog_enabled_out  = wd_en_q;
endmodule
`default_nettype wire

/* tb/hprw_checker.sv */
// Concurrent checks on the supervisor's ports
`timescale 1ns/1ps
`default_nettype none
module hprw_checker (
	// Clock and reset
	input wire logic       clk_in,
	input wire logic       rst_n_in,
	input wire logic       ce_in,
	// Command port
	input wire logic       cmd_valid_in,
	input wire logic [7:0] cmd_type_in,
	input wire logic [1:0] cmd_len_in,
	input wire logic [7:0] cmd_data0_in,
	input wire logic [7:0] cmd_data1_in,
	input wire logic       cmd_ready_out,
	input wire logic       rsp_valid_out,
	input wire logic [7:0] rsp_type_out,
	// Keypad and sense
	input wire logic       poll_in,
	input wire logic       poll_valid_out,
	input wire logic       host_sense_out,
	// Host lines and display
	input wire logic       reset_pin_out,
	input wire logic       reset_pin_oe_out,
	input wire logic       power_pin_out,
	input wire logic       power_pin_oe_out,
	input wire logic       display_blank_out,
	input wire logic       backlight_off_out,
	// Status
	input wire logic [7:0] func_mask_out,
	input wire logic [7:0] pulse_len_out,
	input wire logic       wdog_enabled_out
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	wire take = cmd_valid_in && cmd_ready_out && ce_in;

	chk_atx_answer: assert property (take && cmd_type_in == 8'h1c |=> rsp_valid_out && rsp_type_out == 8'h5c)
		else $error("switch command not answered");
	chk_wdog_answer: assert property (take && cmd_type_in == 8'h1d |=> rsp_valid_out && rsp_type_out == 8'h5d)
		else $error("watchdog command not answered");
	chk_rsp_cause: assert property (rsp_valid_out |-> $past(take))
		else $error("answer without a command");
	chk_mask_load: assert property (take && cmd_type_in == 8'h1c |=> func_mask_out == $past(cmd_data0_in))
		else $error("function mask not loaded");
	chk_len_load: assert property (take && cmd_type_in == 8'h1c && cmd_len_in >= 2'd2
		|=> pulse_len_out == $past(cmd_data1_in))
		else $error("pulse length not loaded");
	chk_wdog_zero: assert property (take && cmd_type_in == 8'h1d && cmd_data0_in == 8'h00 |=> !wdog_enabled_out)
		else $error("watchdog left enabled");
	chk_poll_answer: assert property (poll_in && ce_in |=> poll_valid_out)
		else $error("poll not answered");
	chk_reset_level: assert property (reset_pin_oe_out && !func_mask_out[0] |-> reset_pin_out == func_mask_out[1])
		else $error("reset line drive level wrong");
	chk_power_level: assert property (power_pin_oe_out && !func_mask_out[0] |-> power_pin_out == func_mask_out[2])
		else $error("power line drive level wrong");
	chk_blank_follow: assert property (func_mask_out[4] && !host_sense_out [*2]
		|-> display_blank_out && backlight_off_out)
		else $error("display not blanked");
endmodule
bind hprw_top hprw_checker hprw_checker_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
	.cmd_valid_in(cmd_valid_in), .cmd_type_in(cmd_type_in), .cmd_len_in(cmd_len_in),
	.cmd_data0_in(cmd_data0_in), .cmd_data1_in(cmd_data1_in), .cmd_ready_out(cmd_ready_out),
	.rsp_valid_out(rsp_valid_out), .rsp_type_out(rsp_type_out), .poll_in(poll_in),
	.poll_valid_out(poll_valid_out), .host_sense_out(host_sense_out), .reset_pin_out(reset_pin_out),
	.reset_pin_oe_out(reset_pin_oe_out), .power_pin_out(power_pin_out), .power_pin_oe_out(power_pin_oe_out),
	.display_blank_out(display_blank_out), .backlight_off_out(backlight_off_out),
	.func_mask_out(func_mask_out), .pulse_len_out(pulse_len_out), .wdog_enabled_out(wdog_enabled_out));
`default_nettype wire

/* tb/hprw_host_model.sv */
// Behavioural host power supply and reset circuitry
`timescale 1ns/1ps
`default_nettype none
module hprw_host_model (
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	// Supervisor drive
	input  wire logic       rst_lvl_in,
	input  wire logic       rst_oe_in,
	input  wire logic       pwr_lvl_in,
	input  wire logic       pwr_oe_in,
	// Host side
	output logic            rst_line_out,
	output logic            pwr_line_out,
	output logic            host_on_out,
	output logic [7:0]      resets_out
);
	// ----------------------------------------
	// Lines and host state
	// ----------------------------------------
	logic pwr_oe_q;
	logic rst_oe_q;
	// Pulled up while released, so a floating line reads high
	assign rst_line_out = rst_oe_in ? rst_lvl_in : 1'b1;
	assign pwr_line_out = pwr_oe_in ? pwr_lvl_in : 1'b1;
	// Like a front-panel button, the host toggles when the press ends
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pwr_oe_q <= 1'b0;
			rst_oe_q <= 1'b0;
			host_on_out <= 1'b1;
			resets_out <= 8'h00;
		end else begin
			pwr_oe_q <= pwr_oe_in;
			rst_oe_q <= rst_oe_in;
			if (pwr_oe_q && !pwr_oe_in)
				host_on_out <= !host_on_out;
			if (rst_oe_in && !rst_oe_q)
				resets_out <= resets_out + 8'h01;
		end
	end
endmodule
`default_nettype wire

/* tb/tb_hprw_top.sv */
// Self-checking bench for the host supervisor
`timescale 1ns/1ps
`default_nettype none
module tb_hprw_top;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        clk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic        cmd_valid_in = 1'b0;
	logic [7:0]  cmd_type_in = 8'h00;
	logic [1:0]  cmd_len_in = 2'd0;
	logic [7:0]  cmd_data0_in = 8'h00;
	logic [7:0]  cmd_data1_in = 8'h00;
	logic [7:0]  cmd_data2_in = 8'h00;
	logic [5:0]  key_pins_in = 6'h00;
	logic        poll_in = 1'b0;
	wire         cmd_ready_out, rsp_valid_out, poll_valid_out, host_sense_out;
	wire         reset_pin_out, reset_pin_oe_out, power_pin_out, power_pin_oe_out;
	wire         display_blank_out, backlight_off_out, sense_sel_out, wdog_enabled_out, self_reset_out;
	wire         rst_line, pwr_line, host_on;
	wire [7:0]   rsp_type_out, func_mask_out, pulse_len_out, wdog_count_out, resets;
	wire [5:0]   keys_down_out, keys_pressed_out, keys_released_out;
	wire [1:0]   message_out;
	int          failures = 0;
	int          n_checks = 0;
	int          waited;
	logic [16:0] lfsr_q = 17'd67036;
	logic [7:0]  a, b, c;
	logic [7:0]  boots = 8'h00;

	always #10 clk_in = ~clk_in;
	// Counts device reboots seen on the self reset pulse
	always @(posedge clk_in)
		if (self_reset_out === 1'b1)
			boots <= boots + 8'h01;

	hprw_top #(.TICK_CYCLES(8)) hprw_top_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1),
		.cmd_valid_in(cmd_valid_in), .cmd_type_in(cmd_type_in), .cmd_len_in(cmd_len_in),
		.cmd_data0_in(cmd_data0_in), .cmd_data1_in(cmd_data1_in), .cmd_data2_in(cmd_data2_in),
		.cmd_ready_out(cmd_ready_out), .rsp_valid_out(rsp_valid_out), .rsp_type_out(rsp_type_out),
		.key_pins_in(key_pins_in), .poll_in(poll_in), .poll_valid_out(poll_valid_out),
		.keys_down_out(keys_down_out), .keys_pressed_out(keys_pressed_out), .keys_released_out(keys_released_out),
		.sense_5v_in(host_on), .sense_gpio_in(host_on), .host_sense_out(host_sense_out),
		.reset_pin_in(rst_line), .reset_pin_out(reset_pin_out), .reset_pin_oe_out(reset_pin_oe_out),
		.power_pin_in(pwr_line), .power_pin_out(power_pin_out), .power_pin_oe_out(power_pin_oe_out),
		.display_blank_out(display_blank_out), .backlight_off_out(backlight_off_out), .message_out(message_out),
		.self_reset_out(self_reset_out), .func_mask_out(func_mask_out), .pulse_len_out(pulse_len_out),
		.sense_sel_out(sense_sel_out), .wdog_count_out(wdog_count_out), .wdog_enabled_out(wdog_enabled_out));

	hprw_host_model hprw_host_model_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .rst_lvl_in(reset_pin_out),
		.rst_oe_in(reset_pin_oe_out), .pwr_lvl_in(power_pin_out), .pwr_oe_in(power_pin_oe_out),
		.rst_line_out(rst_line), .pwr_line_out(pwr_line), .host_on_out(host_on), .resets_out(resets));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [16:0] lfsr_next(input logic [16:0] s);
		return {s[15:0], s[16] ^ s[13]};
	endfunction
	function automatic logic exp_sel(input logic [7:0] d);
		return d != 8'h00;
	endfunction
	task automatic rnd();
		lfsr_q = lfsr_next(lfsr_q);
		c = lfsr_q[7:0];
	endtask
	task automatic report_and_stop();
		if (failures == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Waits on negedges; 0 reset oe, 1 power oe, 2 ready
	task automatic wait_sig(input int sel, input logic lvl, input int lim);
		logic v;
		for (waited = 0; waited < lim; waited++) begin
			@(negedge clk_in);
			v = (sel == 0) ? reset_pin_oe_out : (sel == 1) ? power_pin_oe_out : cmd_ready_out;
			if (v === lvl)
				return;
		end
		failures++;
		report_and_stop();
	endtask
	task automatic send(input logic [7:0] t, input logic [1:0] n, input logic [7:0] d0, d1, d2);
		wait_sig(2, 1'b1, 400);
		cmd_type_in = t;
		cmd_len_in = n;
		cmd_data0_in = d0;
		cmd_data1_in = d1;
		cmd_data2_in = d2;
		cmd_valid_in = 1'b1;
		@(negedge clk_in);
		cmd_valid_in = 1'b0;
		chk("rsp", {rsp_valid_out, rsp_type_out}, {1'b1, (t == 8'h1d) ? 8'h5d : 8'h5c});
	endtask
	task automatic do_poll();
		poll_in = 1'b1;
		@(negedge clk_in);
		poll_in = 1'b0;
		chk("poll_valid", poll_valid_out, 1'b1);
	endtask

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge clk_in);
		@(negedge clk_in);
		chk("reset_vals", {func_mask_out, pulse_len_out, sense_sel_out}, {8'h00, 8'd32, 1'b1});
		chk("oe_idle", {reset_pin_oe_out, power_pin_oe_out}, 2'b00);
		rst_n_in = 1'b1;
		repeat (4) begin
			rnd();
			a = c & 8'h07;
			rnd();
			b = c;
			rnd();
			send(8'h1c, 2'd3, a, b, c);
			chk("cfg", {func_mask_out, pulse_len_out, sense_sel_out}, {a, b, exp_sel(c)});
		end
		send(8'h1c, 2'd1, 8'h00, 8'h55, 8'h00);
		chk("len_kept", pulse_len_out, b);
		// Automatic polarity: pulled-up idle line is driven low
		send(8'h1c, 2'd3, 8'h01, 8'd4, 8'h01);
		// Watchdog: off, on, fed twice, then starved
		send(8'h1d, 2'd1, 8'd0, 8'h00, 8'h00);
		chk("wdog_off", wdog_enabled_out, 1'b0);
		send(8'h1d, 2'd1, 8'd2, 8'h00, 8'h00);
		chk("wdog_on", {wdog_enabled_out, wdog_count_out}, {1'b1, 8'd2});
		repeat (2) begin
			repeat (400) @(negedge clk_in);
			chk("fed", reset_pin_oe_out, 1'b0);
			send(8'h1d, 2'd1, 8'd2, 8'h00, 8'h00);
		end
		wait_sig(0, 1'b1, 600);
		chk("wdog_time", waited >= 495 && waited <= 530, 1'b1);
		chk("wdog_fire", {rst_line, wdog_enabled_out}, 2'b00);
		wait_sig(0, 1'b0, 300);
		chk("rst_len", waited >= 240 && waited <= 270, 1'b1);
		repeat (600) @(negedge clk_in);
		chk("one_reset", resets, 8'd1);
		// Keypad reset with inverted drive
		send(8'h1c, 2'd1, 8'h22, 8'h00, 8'h00);
		a = boots;
		key_pins_in = 6'h02;
		wait_sig(0, 1'b1, 1100);
		chk("kr_hold", waited >= 1000, 1'b1);
		chk("kr_state", {reset_pin_out, message_out, cmd_ready_out}, {1'b1, 2'd1, 1'b0});
		key_pins_in = 6'h00;
		wait_sig(0, 1'b0, 300);
		chk("kr_len", waited >= 240 && waited <= 270, 1'b1);
		chk("kr_lock", cmd_ready_out, 1'b0);
		wait_sig(2, 1'b1, 300);
		chk("kr_boot", boots, a + 8'h01);
		// Power off held past the pulse, capped by the extension
		send(8'h1c, 2'd3, 8'h90, 8'd4, 8'h01);
		key_pins_in = 6'h04;
		wait_sig(1, 1'b1, 1100);
		chk("poff", {power_pin_out, message_out}, {1'b0, 2'd3});
		wait_sig(1, 1'b0, 1400);
		chk("poff_cap", waited >= 1290 && waited <= 1330, 1'b1);
		key_pins_in = 6'h00;
		repeat (6) @(negedge clk_in);
		chk("host_off", {host_sense_out, display_blank_out, backlight_off_out, cmd_ready_out}, 4'b0111);
		// Power on from standby
		send(8'h1c, 2'd3, 8'hd0, 8'd4, 8'h01);
		key_pins_in = 6'h02;
		wait_sig(1, 1'b1, 120);
		chk("pon", {waited >= 56, message_out}, {1'b1, 2'd2});
		key_pins_in = 6'h00;
		wait_sig(1, 1'b0, 60);
		chk("pon_len", waited >= 24 && waited <= 40, 1'b1);
		wait_sig(2, 1'b1, 400);
		chk("host_on", {host_sense_out, display_blank_out}, 2'b10);
		chk("pon_boot", boots, a + 8'h02);
		// Polled keypad
		send(8'h1c, 2'd1, 8'h00, 8'h00, 8'h00);
		do_poll();
		repeat (3) begin
			rnd();
			key_pins_in = c[5:0];
			repeat (4) @(negedge clk_in);
			do_poll();
			chk("down", {keys_down_out, keys_pressed_out}, {c[5:0], c[5:0]});
			key_pins_in = 6'h00;
			repeat (4) @(negedge clk_in);
			do_poll();
			chk("up", {keys_down_out, keys_released_out}, {6'h00, c[5:0]});
		end
		report_and_stop();
	end
endmodule
`default_nettype wire
